/* File: rtl/siu_pkg.sv */
// constants and types for the sequencer interrupt unit
// How it works
// - interrupt request is sampled at the clock edge; late requests count next cycle.
// - in call mode an interrupt is acted on only while the line's mask bit is 0; interrupt jump lines ignore it.
// - enable setting, plus a rising or falling edge select.
// - exactly two handling modes: vectored call or conditional jump test.
// - call mode saves return address, runs routine, resumes after interrupted line.
// - return on the routine's last line resumes after the interrupted line.
// - flow instructions on the routine's first line are ignored.
// - interrupt seen inside the routine waits until the routine returns.
// - jump mode tests only on interrupt jump lines, branches without return address.
// - each interrupt jump line carries its own destination.
// - in call mode each line has a mask bit blocking service.
// - interrupt jump dead in call mode, return dead in jump mode; mode frozen.
// - pending request cleared at start; first line test may miss.
// - call mode reserves word 0 for routine address; lines shift up one.
// - disabled or jump mode: lines start at word 0.
// - qualifier active level selectable high or low.
// - qualifier defaults to don't care and then gates nothing.
package siu_pkg;

    // ========================================
    // widths and addresses
    localparam int SEQ_W  = 12;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 12'h001;

    // ========================================
    // timing
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int QUAL_SETUP_NS  = 15;
    localparam int QUAL_SETUP_CYC =
        (QUAL_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int QCNT_W = 3;
    localparam logic [QCNT_W-1:0] QCNT_FULL = QCNT_W'(QUAL_SETUP_CYC);
    localparam logic [QCNT_W-1:0] QCNT_RST  = 3'h0;

    // ========================================
    // enumerations
    typedef enum logic [2:0] {
        OP_NOP    = 3'h0,
        OP_JUMP   = 3'h1,
        OP_RETURN = 3'h2,
        OP_IF_IRQ = 3'h3,
        OP_HALT   = 3'h4
    } siu_op_t;

    typedef enum logic [1:0] {
        QUAL_ANY  = 2'h0,
        QUAL_LOW  = 2'h1,
        QUAL_HIGH = 2'h2
    } siu_qual_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_VEC  = 3'h2,
        ST_RUN  = 3'h4
    } siu_state_t;

    // ========================================
    // carriers
    typedef struct packed {
        logic      irq_en;
        logic      irq_fall;
        logic      call_mode;
        siu_qual_t qual_sel;
    } siu_cfg_t;

    typedef struct packed {
        siu_op_t          op;
        logic             mask;
        logic [SEQ_W-1:0] dest;
    } siu_instr_t;

endpackage

/* File: rtl/siu_irq_detect.sv */
// edge detector and qualifier gate for the interrupt request line
`timescale 1ns/1ps
`default_nettype none
module siu_irq_detect (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // configuration
    input  wire siu_pkg::siu_cfg_t cfg,
    // probe lines
    input  wire logic        irq_in,
    input  wire logic        qual_in,
    // detected event
    output logic             irq_evt_r
);
    import siu_pkg::*;

    logic              irq_q_r;
    logic              armed_r;
    logic [QCNT_W-1:0] qcnt_r;
    logic [QCNT_W-1:0] qcnt_nxt;
    logic              qual_act;
    logic              qual_ok;
    logic              edge_seen;
    logic              evt_nxt;

    // ========================================
    // decode
    // qualifier level per selected polarity
    assign qual_act  = (cfg.qual_sel == QUAL_HIGH) ? qual_in : ~qual_in;
    assign qcnt_nxt  = !qual_act ? QCNT_RST :
                       (qcnt_r == QCNT_FULL) ? qcnt_r : qcnt_r + 3'h1;
    // don't care never gates
    assign qual_ok   = (cfg.qual_sel == QUAL_ANY) || (qcnt_r == QCNT_FULL);
    // edge between last and present sample; none before the first
    // sample, so a line idling high cannot fake a rising edge
    assign edge_seen = armed_r
                     & (cfg.irq_fall ? (irq_q_r & ~irq_in)
                                     : (~irq_q_r & irq_in));
    assign evt_nxt   = cfg.irq_en & edge_seen & qual_ok;

    // ========================================
    // sample registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q_r   <= 1'b0;
            armed_r   <= 1'b0;
            qcnt_r    <= QCNT_RST;
            irq_evt_r <= 1'b0;
        end else if (ce) begin
            irq_q_r   <= irq_in;
            armed_r   <= 1'b1;
            qcnt_r    <= qcnt_nxt;
            irq_evt_r <= evt_nxt;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_evt_needs_enable;
        ce && !cfg.irq_en |=> !irq_evt_r;
    endproperty
    a_evt_needs_enable: assert property (p_evt_needs_enable)
        else $error("event raised while interrupt disabled");

    property p_qual_gate;
        ce && cfg.qual_sel != QUAL_ANY && qcnt_r != QCNT_FULL |=> !irq_evt_r;
    endproperty
    a_qual_gate: assert property (p_qual_gate)
        else $error("event accepted without qualifier setup");

    property p_edge_event;
        ce && cfg.irq_en && cfg.qual_sel == QUAL_ANY && !cfg.irq_fall
            && armed_r && !irq_q_r && irq_in |=> irq_evt_r;
    endproperty
    a_edge_event: assert property (p_edge_event)
        else $error("rising edge not seen next cycle");

    c_evt: cover property (ce && irq_evt_r);
endmodule
`default_nettype wire

/* File: rtl/siu_top.sv */
// sequencer program counter with call and jump interrupt handling
`timescale 1ns/1ps
`default_nettype none
module siu_top (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        ce,
    // configuration
    input  wire siu_pkg::siu_cfg_t           cfg,
    // control
    input  wire logic                        start,
    // probe lines
    input  wire logic                        irq_in,
    input  wire logic                        qual_in,
    // program memory
    input  wire siu_pkg::siu_instr_t         prog_word,
    output logic [siu_pkg::ADDR_W-1:0]       prog_addr_r,
    // status
    output logic                             running_r,
    output logic                             in_isr_r,
    output logic                             pending_r,
    output logic                             taken_r
);
    import siu_pkg::*;

    // ========================================
    // state
    siu_state_t        state_r;
    siu_state_t        state_nxt;
    logic              call_mode_r;
    logic              irq_en_r;
    logic              base_r;
    logic              first_r;
    logic [ADDR_W-1:0] svc_r;
    logic [ADDR_W-1:0] ret_r;
    logic              irq_evt;

    // ========================================
    // edge detector
    siu_irq_detect u_det (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .cfg       (cfg),
        .irq_in    (irq_in),
        .qual_in   (qual_in),
        .irq_evt_r (irq_evt)
    );

    // ========================================
    // decode of the executing line
    logic              st_run;
    logic              st_vec;
    logic              base_nxt;
    logic [ADDR_W-1:0] pc_inc;
    logic [ADDR_W-1:0] dest_addr;
    logic              op_halt;
    logic              call_act;
    logic              ret_act;
    logic              jmp_act;
    logic              ifirq_act;
    logic              svc_done;

    assign st_run    = (state_r == ST_RUN);
    assign st_vec    = (state_r == ST_VEC);
    // word 0 reserved only for enabled call mode
    assign base_nxt  = cfg.irq_en & cfg.call_mode;
    assign pc_inc    = prog_addr_r + ADDR_ONE;
    // sequence line to memory address
    assign dest_addr = prog_word.dest + {{(ADDR_W-1){1'b0}}, base_r};
    assign op_halt   = st_run & (prog_word.op == OP_HALT);

    // vectored call on an unmasked line, never nested
    assign call_act  = st_run & !op_halt & call_mode_r & irq_en_r
                     & pending_r & !in_isr_r & !first_r
                     & !prog_word.mask;

    // return only exists in call mode, only inside the routine
    assign ret_act   = st_run & !op_halt & !call_act & !first_r
                     & call_mode_r & in_isr_r
                     & (prog_word.op == OP_RETURN);

    // flow on the routine's first line is dropped
    assign jmp_act   = st_run & !op_halt & !call_act & !first_r
                     & (prog_word.op == OP_JUMP);

    // interrupt jump only in jump mode, no return saved
    assign ifirq_act = st_run & !op_halt & !call_mode_r & irq_en_r
                     & pending_r
                     & (prog_word.op == OP_IF_IRQ);

    assign svc_done  = call_act | ifirq_act;

    // ========================================
    // next program address
    logic [ADDR_W-1:0] pc_nxt;

    assign pc_nxt = start     ? ADDR_ZERO :
                    st_vec    ? ADDR_ONE :
                    !st_run   ? prog_addr_r :
                    op_halt   ? prog_addr_r :
                    call_act  ? svc_r :
                    ret_act   ? ret_r :
                    jmp_act   ? dest_addr :
                    ifirq_act ? dest_addr :
                    pc_inc;

    // ========================================
    // sequencer state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_IDLE;
            end
            ST_VEC: begin
                state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (op_halt) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (start) begin
            state_nxt = base_nxt ? ST_VEC : ST_RUN;
        end
    end

    // ========================================
    // pending request: new event beats a service clear,
    // start clears outright
    logic pending_nxt;

    assign pending_nxt = start ? 1'b0 :
                         (irq_evt | (pending_r & !svc_done));

    // routine flag
    logic in_isr_nxt;

    assign in_isr_nxt = start    ? 1'b0 :
                        call_act ? 1'b1 :
                        ret_act  ? 1'b0 :
                        in_isr_r;

    // ========================================
    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= ST_IDLE;
            prog_addr_r <= ADDR_ZERO;
            pending_r   <= 1'b0;
            in_isr_r    <= 1'b0;
        end else if (ce) begin
            state_r     <= state_nxt;
            prog_addr_r <= pc_nxt;
            pending_r   <= pending_nxt;
            in_isr_r    <= in_isr_nxt;
        end
    end

    // mode is frozen for the whole run
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            call_mode_r <= 1'b0;
            irq_en_r    <= 1'b0;
            base_r      <= 1'b0;
        end else if (ce && start) begin
            call_mode_r <= cfg.call_mode;
            irq_en_r    <= cfg.irq_en;
            base_r      <= base_nxt;
        end
    end

    // routine address from word 0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            svc_r <= ADDR_ZERO;
        end else if (ce && st_vec) begin
            svc_r <= prog_word.dest;
        end
    end

    // return address and first-line marker
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ret_r   <= ADDR_ZERO;
            first_r <= 1'b0;
        end else if (ce) begin
            first_r <= call_act & !start;
            if (call_act) begin
                ret_r <= pc_inc;
            end
        end
    end

    // status outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            running_r <= 1'b0;
            taken_r   <= 1'b0;
        end else if (ce) begin
            running_r <= (state_nxt != ST_IDLE);
            taken_r   <= svc_done & !start;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_call_vec;
        ce && call_act && !start |=> prog_addr_r == svc_r && in_isr_r;
    endproperty
    a_call_vec: assert property (p_call_vec)
        else $error("call did not go to routine address");

    property p_ret;
        ce && ret_act && !start
            |=> prog_addr_r == $past(ret_r) && !in_isr_r;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return did not resume after interrupted line");

    property p_mask;
        ce && st_run && prog_word.mask && !in_isr_r && !start
            |=> !in_isr_r;
    endproperty
    a_mask: assert property (p_mask)
        else $error("routine entered on a masked line");

    property p_first_ignored;
        ce && st_run && first_r && !op_halt && !start
            |=> prog_addr_r == $past(prog_addr_r) + ADDR_ONE;
    endproperty
    a_first_ignored: assert property (p_first_ignored)
        else $error("flow on routine first line not ignored");

    property p_nest_wait;
        ce && in_isr_r && pending_r && !ret_act && !start
            |=> pending_r && in_isr_r;
    endproperty
    a_nest_wait: assert property (p_nest_wait)
        else $error("nested interrupt not held pending");

    property p_ifirq;
        ce && ifirq_act && !start |=> prog_addr_r == $past(dest_addr)
            && !in_isr_r;
    endproperty
    a_ifirq: assert property (p_ifirq)
        else $error("interrupt jump went wrong");

    property p_ifirq_dead_in_call;
        ce && st_run && call_mode_r && !call_act && !first_r && !start
            && prog_word.op == OP_IF_IRQ
            |=> prog_addr_r == $past(pc_inc);
    endproperty
    a_ifirq_dead_in_call: assert property (p_ifirq_dead_in_call)
        else $error("interrupt jump acted in call mode");

    property p_start_clear;
        ce && start |=> !pending_r && prog_addr_r == ADDR_ZERO;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start did not clear pending or address");

    property p_base_shift;
        ce && start && base_nxt ##1 ce && !start
            |=> prog_addr_r == ADDR_ONE && st_run;
    endproperty
    a_base_shift: assert property (p_base_shift)
        else $error("call mode did not shift first line");

    property p_no_shift;
        ce && start && !base_nxt |=> st_run && prog_addr_r == ADDR_ZERO;
    endproperty
    a_no_shift: assert property (p_no_shift)
        else $error("line zero not at word zero");

    property p_vec_load;
        ce && st_vec && !start |=> svc_r == $past(prog_word.dest);
    endproperty
    a_vec_load: assert property (p_vec_load)
        else $error("routine address not taken from word zero");

    property p_ret_dead_in_jump;
        ce && st_run && !call_mode_r && !start
            && prog_word.op == OP_RETURN
            |=> prog_addr_r == $past(pc_inc);
    endproperty
    a_ret_dead_in_jump: assert property (p_ret_dead_in_jump)
        else $error("return acted in jump mode");

    property p_pend_set;
        ce && irq_evt && !start |=> pending_r;
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("new request not latched as pending");

    c_call:  cover property (ce && call_act);
    c_ret:   cover property (ce && ret_act);
    c_ifirq: cover property (ce && ifirq_act);
    c_nest:  cover property (ce && in_isr_r && irq_evt);
endmodule
`default_nettype wire

/* File: verif/siu_irq_src.sv */
// model of the probe driving interrupt request and qualifier
`timescale 1ns/1ps
`default_nettype none
module siu_irq_src (
    // clock
    input  wire logic clk,
    // probe lines
    output var logic  irq_in,
    output var logic  qual_in
);
    import siu_pkg::*;

    // ==========
    // line drivers, changed just after a rising edge
    initial begin
        irq_in  = 1'b0;
        qual_in = 1'b0;
    end

    task automatic set_lines(input logic irq, input logic qual);
        @(posedge clk);
        irq_in  <= irq;
        qual_in <= qual;
    endtask

    // qualifier settles a full setup time before the request edge
    task automatic qual_edge(input logic irq, input logic qual);
        set_lines(irq_in, qual);
        repeat (QUAL_SETUP_CYC + 1) @(posedge clk);
        irq_in <= irq;
    endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the sequencer interrupt unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import siu_pkg::*;

    // ==========
    // signals
    logic              clk;
    logic              arst_n;
    logic              ce;
    siu_cfg_t          cfg;
    logic              start;
    logic              irq_in;
    logic              qual_in;
    siu_instr_t        prog_word;
    logic [ADDR_W-1:0] prog_addr_r;
    logic              running_r;
    logic              in_isr_r;
    logic              pending_r;
    logic              taken_r;
    logic [ADDR_W-1:0] prev_addr;
    logic              prev_isr;
    siu_instr_t        mem [0:63];
    int                errors;
    int                num_checks;
    int                cycles;
    int                nested;

    // ==========
    // design, probe model and program memory
    siu_top u_dut (
        .clk         (clk),
        .arst_n      (arst_n),
        .ce          (ce),
        .cfg         (cfg),
        .start       (start),
        .irq_in      (irq_in),
        .qual_in     (qual_in),
        .prog_word   (prog_word),
        .prog_addr_r (prog_addr_r),
        .running_r   (running_r),
        .in_isr_r    (in_isr_r),
        .pending_r   (pending_r),
        .taken_r     (taken_r)
    );
    siu_irq_src u_src (
        .clk     (clk),
        .irq_in  (irq_in),
        .qual_in (qual_in)
    );
    assign prog_word = mem[prog_addr_r[5:0]];

    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // previous-cycle history, nesting watch and timeout
    always @(posedge clk) begin
        prev_addr <= prog_addr_r;
        prev_isr  <= in_isr_r;
        cycles    <= cycles + 1;
        if (taken_r === 1'b1 && prev_isr === 1'b1) begin
            nested <= nested + 1;
        end
        if (cycles == 5000) begin
            errors = errors + 1;
            conclude();
        end
    end

    // ==========
    // compares and helpers
    task automatic check_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %b got %b", n, e, g);
        end
    endtask

    task automatic check_addr(input string n, input logic [ADDR_W-1:0] e,
                              input logic [ADDR_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h got %h", n, e, g);
        end
    endtask

    function automatic siu_instr_t mk(siu_op_t op, logic m, int d);
        return '{op, m, SEQ_W'(d)};
    endfunction

    task automatic clear_mem;
        @(posedge clk);
        foreach (mem[i]) mem[i] <= mk(OP_NOP, 1'b0, 0);
    endtask

    task automatic set_cfg(input logic en, input logic fall,
                           input logic call, input siu_qual_t qs);
        @(posedge clk);
        cfg <= '{en, fall, call, qs};
    endtask

    task automatic pulse_start;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic wait_addr(input logic [ADDR_W-1:0] a);
        int n = 0;
        @(negedge clk);
        while (prog_addr_r !== a && n < 40) begin
            @(negedge clk);
            n++;
        end
        check_addr("address reached", a, prog_addr_r);
    endtask

    task automatic wait_taken;
        int n = 0;
        @(negedge clk);
        while (taken_r !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check_bit("taken", 1'b1, taken_r);
    endtask

    task automatic step_addr(input logic [ADDR_W-1:0] a);
        @(negedge clk);
        check_addr("next address", a, prog_addr_r);
    endtask

    // ==========
    // jump test mode: stale request, dead return, branch
    task automatic t_jump;
        clear_mem();
        mem[1] <= mk(OP_RETURN, 1'b0, 7);
        mem[3] <= mk(OP_IF_IRQ, 1'b0, 9);
        mem[4] <= mk(OP_JUMP, 1'b0, 0);
        mem[9] <= mk(OP_HALT, 1'b0, 0);
        set_cfg(1'b1, 1'b0, 1'b0, QUAL_ANY);
        u_src.set_lines(1'b1, 1'b0);
        repeat (6) @(posedge clk);
        pulse_start();
        step_addr(ADDR_ZERO);
        check_bit("start clears", 1'b0, pending_r);
        step_addr(ADDR_ONE);
        step_addr(12'h002);
        step_addr(12'h003);
        step_addr(12'h004);
        step_addr(ADDR_ZERO);
        u_src.set_lines(1'b0, 1'b0);
        u_src.set_lines(1'b1, 1'b0);
        wait_taken();
        check_addr("test line", 12'h003, prev_addr);
        check_addr("branch dest", 12'h009, prog_addr_r);
        check_bit("serviced", 1'b0, pending_r);
        check_bit("no routine", 1'b0, in_isr_r);
        repeat (3) @(negedge clk);
        check_bit("halted", 1'b0, running_r);
    endtask

    // ==========
    // call mode: shift, mask, routine, deferral, freeze
    task automatic t_call;
        logic [ADDR_W-1:0] a;
        clear_mem();
        mem[0]  <= mk(OP_NOP, 1'b1, 20);
        mem[1]  <= mk(OP_NOP, 1'b1, 0);
        mem[2]  <= mk(OP_IF_IRQ, 1'b1, 30);
        mem[3]  <= mk(OP_NOP, 1'b0, 0);
        mem[4]  <= mk(OP_NOP, 1'b1, 0);
        mem[5]  <= mk(OP_JUMP, 1'b1, 0);
        mem[20] <= mk(OP_JUMP, 1'b0, 5);
        mem[28] <= mk(OP_RETURN, 1'b0, 0);
        set_cfg(1'b1, 1'b0, 1'b1, QUAL_ANY);
        u_src.set_lines(1'b0, 1'b0);
        pulse_start();
        wait_addr(12'h005);
        step_addr(ADDR_ONE);
        u_src.set_lines(1'b1, 1'b0);
        wait_taken();
        check_addr("unmasked line", 12'h003, prev_addr);
        check_addr("routine entry", 12'h014, prog_addr_r);
        check_bit("in routine", 1'b1, in_isr_r);
        step_addr(12'h015);
        u_src.set_lines(1'b0, 1'b0);
        u_src.set_lines(1'b1, 1'b0);
        wait_addr(12'h01C);
        check_bit("held pending", 1'b1, pending_r);
        step_addr(12'h004);
        check_bit("routine left", 1'b0, in_isr_r);
        wait_taken();
        check_addr("deferred call", 12'h003, prev_addr);
        check_bit("no nesting", 1'b1, nested == 0);
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        a = prog_addr_r;
        repeat (3) @(negedge clk);
        check_addr("frozen", a, prog_addr_r);
        @(posedge clk);
        ce <= 1'b1;
    endtask

    // ==========
    // enable, edge select and qualifier acceptance
    task automatic try_req(input logic en, input logic fall,
                           input logic idle, input siu_qual_t qs,
                           input logic ql, input logic late,
                           input logic e);
        set_cfg(en, fall, 1'b0, qs);
        u_src.set_lines(idle, late ? ~ql : ql);
        repeat (6) @(posedge clk);
        pulse_start();
        if (late) begin
            u_src.set_lines(~idle, ql);
        end else begin
            u_src.qual_edge(~idle, ql);
        end
        repeat (8) @(negedge clk);
        check_bit("request accepted", e, pending_r);
        repeat (20) @(negedge clk);
        check_bit("request latched", e, pending_r);
    endtask

    task automatic t_qual;
        clear_mem();
        mem[1] <= mk(OP_JUMP, 1'b0, 0);
        try_req(1'b0, 1'b0, 1'b0, QUAL_ANY, 1'b0, 1'b0, 1'b0);
        try_req(1'b1, 1'b0, 1'b0, QUAL_ANY, 1'b0, 1'b0, 1'b1);
        try_req(1'b1, 1'b1, 1'b1, QUAL_ANY, 1'b0, 1'b0, 1'b1);
        try_req(1'b1, 1'b1, 1'b0, QUAL_ANY, 1'b0, 1'b0, 1'b0);
        try_req(1'b1, 1'b0, 1'b0, QUAL_HIGH, 1'b1, 1'b0, 1'b1);
        try_req(1'b1, 1'b0, 1'b0, QUAL_HIGH, 1'b0, 1'b0, 1'b0);
        try_req(1'b1, 1'b0, 1'b0, QUAL_LOW, 1'b0, 1'b0, 1'b1);
        try_req(1'b1, 1'b0, 1'b0, QUAL_HIGH, 1'b1, 1'b1, 1'b0);
    endtask

    // ==========
    // verdict
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        arst_n     = 1'b0;
        ce         = 1'b1;
        cfg        = '0;
        start      = 1'b0;
        errors     = 0;
        num_checks = 0;
        cycles     = 0;
        nested     = 0;
        clear_mem();
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check_bit("idle after reset", 1'b0, running_r);
        check_addr("reset address", ADDR_ZERO, prog_addr_r);
        t_jump();
        t_call();
        t_qual();
        conclude();
    end
endmodule
`default_nettype wire
